/* File: design/uart_pkg.sv */
// constants, types and field layouts of the serial port control block
package uart_pkg;

  // ********************************
  // register map (word index, byte address = 4 x index)
  // ********************************
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] IDX_DATA_BUFFER = 8'h99;
  localparam logic [7:0] IDX_BAUD_RELOAD = 8'h9A;
  localparam logic [7:0] IDX_BAUD_CONTROL = 8'h9B;
  localparam logic [7:0] IDX_SLAVE_ADDRESS = 8'hA9;
  localparam logic [7:0] IDX_SLAVE_MASK = 8'hB9;
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int PC_FE_ACCESS = 6;
  localparam int PC_RATE_DOUBLER = 7;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ********************************
  // timing
  // ********************************
  localparam logic [3:0] SAMPLE_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_MID = 4'h7;
  localparam logic [1:0] MODE0_HALF_LAST = 2'h2;
  localparam logic [2:0] SLOW_PRESCALE_LAST = 3'h5;
  localparam logic [3:0] FRAME_BITS_8 = 4'hA;
  localparam logic [3:0] FRAME_BITS_9 = 4'hB;
  localparam logic [3:0] SHIFT_BITS = 4'h8;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_UART8 = 2'b01,
    MODE_UART9_FIXED = 2'b10,
    MODE_UART9_VAR = 2'b11
  } mode_e;

  typedef struct packed {
    logic mode_select_bit0;
    logic mode_select_bit1;
    logic multiproc_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } serial_ctrl_s;

  typedef struct packed {
    logic generator_run;
    logic tx_clock_select;
    logic rx_clock_select;
    logic generator_speed_select;
    logic shift_mode_clock_select;
  } baud_ctrl_s;

endpackage

/* File: design/uart_serial_port.sv */
// serial port control: axi4-lite registers, baud generation, transmit and receive engines
`timescale 1ns/1ps
module uart_serial_port import uart_pkg::*; #(
  parameter int AW = ADDR_W
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // timer 1 overflow pulse, same clock
  input wire logic timer1_tick,
  // serial pins
  input wire logic rxd_pin,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd
);

  // the decoders slice awaddr and araddr at fixed bits, so only the default width works
  if (AW != ADDR_W) begin : g_aw_check
    $error("address width must be 10");
  end

  // ********************************
  // register bus
  // ********************************
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, aw_have_ff, w_have_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [7:0] aw_idx_ff, wbyte_ff;
  logic wlane_ff, wr_do;
  logic [7:0] rd_byte;
  logic rd_hit, wr_hit;

  assign wr_do = aw_have_ff && w_have_ff && !bvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      aw_idx_ff <= 8'h00;
      wbyte_ff <= 8'h00;
      wlane_ff <= 1'b0;
    end else begin
      awready_ff <= !aw_have_ff && !(awvalid && awready_ff);
      wready_ff <= !w_have_ff && !(wvalid && wready_ff);
      if (awvalid && awready_ff) begin
        aw_have_ff <= 1'b1;
        aw_idx_ff <= awaddr[9:2];
      end
      if (wvalid && wready_ff) begin
        w_have_ff <= 1'b1;
        wbyte_ff <= wdata[7:0];
        wlane_ff <= wstrb[0];
      end
      if (wr_do) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    if (aw_idx_ff == IDX_SERIAL_CONTROL) wr_hit = 1'b1;
    else if (aw_idx_ff == IDX_DATA_BUFFER) wr_hit = 1'b1;
    else if (aw_idx_ff == IDX_BAUD_RELOAD) wr_hit = 1'b1;
    else if (aw_idx_ff == IDX_BAUD_CONTROL) wr_hit = 1'b1;
    else if (aw_idx_ff == IDX_SLAVE_ADDRESS) wr_hit = 1'b1;
    else if (aw_idx_ff == IDX_SLAVE_MASK) wr_hit = 1'b1;
    else if (aw_idx_ff == IDX_POWER_CONTROL) wr_hit = 1'b1;
    else wr_hit = 1'b0;
  end

  // a write with byte lane 0 off is answered but stores nothing
  logic wr_en;
  assign wr_en = wr_do && wlane_ff;
  logic wr_sc, wr_db, wr_rl, wr_bc, wr_sa, wr_sm, wr_pc;
  assign wr_sc = wr_en && (aw_idx_ff == IDX_SERIAL_CONTROL);
  assign wr_db = wr_en && (aw_idx_ff == IDX_DATA_BUFFER);
  assign wr_rl = wr_en && (aw_idx_ff == IDX_BAUD_RELOAD);
  assign wr_bc = wr_en && (aw_idx_ff == IDX_BAUD_CONTROL);
  assign wr_sa = wr_en && (aw_idx_ff == IDX_SLAVE_ADDRESS);
  assign wr_sm = wr_en && (aw_idx_ff == IDX_SLAVE_MASK);
  assign wr_pc = wr_en && (aw_idx_ff == IDX_POWER_CONTROL);

  // ********************************
  // registers
  // ********************************
  serial_ctrl_s sc_ff;
  baud_ctrl_s bc_ff;
  logic fe_ff;
  logic [7:0] reload_ff, slave_address_ff, smask_ff, dbuf_ff, pwr_ff;
  logic fe_access, rate_doubler;
  mode_e mode;
  logic ti_set, ri_set, fe_set, rx_load;
  logic [7:0] rx_load_data;
  logic rb8_val;

  assign fe_access = pwr_ff[PC_FE_ACCESS];
  assign rate_doubler = pwr_ff[PC_RATE_DOUBLER];
  assign mode = mode_e'({sc_ff.mode_select_bit0, sc_ff.mode_select_bit1});

  // hardware sets win over a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sc_ff <= serial_ctrl_s'(RST_BYTE);
      fe_ff <= 1'b0;
    end else begin
      if (wr_sc) begin
        sc_ff[6:0] <= wbyte_ff[6:0];
        if (fe_access) fe_ff <= wbyte_ff[7];
        else sc_ff.mode_select_bit0 <= wbyte_ff[7];
      end
      if (fe_set) fe_ff <= 1'b1;
      if (ti_set) sc_ff.tx_done_flag <= 1'b1;
      if (ri_set) sc_ff.rx_done_flag <= 1'b1;
      if (rx_load) sc_ff.rx_ninth_bit <= rb8_val;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bc_ff <= baud_ctrl_s'(5'h00);
      reload_ff <= RST_BYTE;
      slave_address_ff <= RST_BYTE;
      smask_ff <= RST_BYTE;
      pwr_ff <= RST_BYTE;
    end else begin
      if (wr_bc) bc_ff <= wbyte_ff[4:0];
      if (wr_rl) reload_ff <= wbyte_ff;
      if (wr_sa) slave_address_ff <= wbyte_ff;
      if (wr_sm) smask_ff <= wbyte_ff;
      if (wr_pc) pwr_ff <= wbyte_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) dbuf_ff <= RST_BYTE;
    else if (rx_load) dbuf_ff <= rx_load_data;
    else if (wr_db) dbuf_ff <= wbyte_ff;
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_byte = 8'h00;
    if (araddr[9:2] == IDX_SERIAL_CONTROL) rd_byte = {fe_access ? fe_ff : sc_ff[7], sc_ff[6:0]};
    else if (araddr[9:2] == IDX_DATA_BUFFER) rd_byte = dbuf_ff;
    else if (araddr[9:2] == IDX_BAUD_RELOAD) rd_byte = reload_ff;
    else if (araddr[9:2] == IDX_BAUD_CONTROL) rd_byte = {3'b000, bc_ff};
    else if (araddr[9:2] == IDX_SLAVE_ADDRESS) rd_byte = slave_address_ff;
    else if (araddr[9:2] == IDX_SLAVE_MASK) rd_byte = smask_ff;
    else if (araddr[9:2] == IDX_POWER_CONTROL) rd_byte = pwr_ff;
    else rd_hit = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else if (arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_byte};
      rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  // ********************************
  // baud sources
  // ********************************
  logic [7:0] brg_cnt_ff;
  logic [2:0] brg_pre_ff;
  logic brg_tick_ff, brg_half_ff, t1_half_ff, cyc_half_ff;
  logic [1:0] m0_div_ff;
  logic brg_step, brg_q, t1_q, m2_tick, tx_samp, rx_samp, m0_tick;

  assign brg_step = bc_ff.generator_run &&
    (bc_ff.generator_speed_select || brg_pre_ff == SLOW_PRESCALE_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brg_cnt_ff <= 8'h00;
      brg_pre_ff <= 3'h0;
      brg_tick_ff <= 1'b0;
    end else begin
      brg_tick_ff <= 1'b0;
      if (bc_ff.generator_run) begin
        brg_pre_ff <= (brg_pre_ff == SLOW_PRESCALE_LAST) ? 3'h0 : brg_pre_ff + 3'h1;
        if (brg_step) begin
          if (brg_cnt_ff == 8'hFF) begin
            brg_cnt_ff <= reload_ff;
            brg_tick_ff <= 1'b1;
          end else begin
            brg_cnt_ff <= brg_cnt_ff + 8'h01;
          end
        end
      end
    end
  end

  // without the doubler every second source tick is used
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brg_half_ff <= 1'b0;
      t1_half_ff <= 1'b0;
      cyc_half_ff <= 1'b0;
      m0_div_ff <= 2'h0;
    end else begin
      if (brg_tick_ff) brg_half_ff <= !brg_half_ff;
      if (timer1_tick) t1_half_ff <= !t1_half_ff;
      cyc_half_ff <= !cyc_half_ff;
      m0_div_ff <= (m0_div_ff == MODE0_HALF_LAST) ? 2'h0 : m0_div_ff + 2'h1;
    end
  end

  assign brg_q = brg_tick_ff && (rate_doubler || brg_half_ff);
  assign t1_q = timer1_tick && (rate_doubler || t1_half_ff);
  assign m2_tick = rate_doubler || cyc_half_ff;
  assign tx_samp = (mode == MODE_UART9_FIXED) ? m2_tick
    : (bc_ff.tx_clock_select ? brg_q : t1_q);
  assign rx_samp = (mode == MODE_UART9_FIXED) ? m2_tick
    : (bc_ff.rx_clock_select ? brg_q : t1_q);
  // with the fixed divider, two half periods of three clocks make one shift bit of six clocks
  assign m0_tick = bc_ff.shift_mode_clock_select ? brg_q
    : (m0_div_ff == MODE0_HALF_LAST);

  // ********************************
  // receive pin synchroniser
  // ********************************
  logic rx_s1_ff, rx_s2_ff, rx_prev_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_s1_ff <= rxd_pin;
      rx_s2_ff <= rx_s1_ff;
      rx_prev_ff <= rx_s2_ff;
    end
  end

  // ********************************
  // transmit engine (also runs mode 0 shifts both ways)
  // ********************************
  logic tx_busy_ff, tx_ph_ff, m0_rx_ff, m0_bit_ff, txd_ff, rxd_out_ff, rxd_oe_ff;
  logic [10:0] tx_sh_ff;
  logic [3:0] tx_left_ff, tx_samp_ff;
  logic nine, tx_load, m0_rx_start, tx_shift, m0_done;

  assign nine = mode[1];
  assign tx_load = wr_db && !tx_busy_ff;
  assign m0_rx_start = (mode == MODE_SHIFT) && sc_ff.rx_enable && !sc_ff.rx_done_flag
    && !tx_busy_ff && !wr_db;
  assign tx_shift = tx_busy_ff && ((mode == MODE_SHIFT) ? (m0_tick && tx_ph_ff)
    : (tx_samp && tx_samp_ff == SAMPLE_LAST));
  assign m0_done = tx_shift && (mode == MODE_SHIFT) && tx_left_ff == 4'h1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_busy_ff <= 1'b0;
      tx_sh_ff <= 11'h7FF;
      tx_left_ff <= 4'h0;
      tx_samp_ff <= 4'h0;
      tx_ph_ff <= 1'b0;
      m0_rx_ff <= 1'b0;
      m0_bit_ff <= 1'b0;
    end else if (!tx_busy_ff) begin
      tx_samp_ff <= 4'h0;
      tx_ph_ff <= 1'b0;
      if (tx_load || m0_rx_start) begin
        tx_busy_ff <= 1'b1;
        m0_rx_ff <= !tx_load;
        if (mode == MODE_SHIFT) begin
          tx_sh_ff <= {3'b111, wbyte_ff};
          tx_left_ff <= SHIFT_BITS;
        end else begin
          tx_sh_ff <= {1'b1, nine ? sc_ff.tx_ninth_bit : 1'b1, wbyte_ff, 1'b0};
          tx_left_ff <= nine ? FRAME_BITS_9 : FRAME_BITS_8;
        end
      end
    end else begin
      if (tx_samp) tx_samp_ff <= tx_samp_ff + 4'h1;
      if (mode == MODE_SHIFT && m0_tick) begin
        tx_ph_ff <= !tx_ph_ff;
        if (!tx_ph_ff) m0_bit_ff <= rx_s2_ff;
      end
      if (tx_shift) begin
        tx_sh_ff <= {m0_rx_ff ? m0_bit_ff : 1'b1, tx_sh_ff[10:1]};
        tx_left_ff <= tx_left_ff - 4'h1;
        if (tx_left_ff == 4'h1) tx_busy_ff <= 1'b0;
      end
    end
  end

  // pins: in mode 0 the receive pin carries data and the transmit pin the shift clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_ff <= 1'b1;
      rxd_out_ff <= 1'b1;
      rxd_oe_ff <= 1'b0;
    end else begin
      txd_ff <= !tx_busy_ff || ((mode == MODE_SHIFT) ? tx_ph_ff : tx_sh_ff[0]);
      rxd_out_ff <= tx_sh_ff[0];
      rxd_oe_ff <= tx_busy_ff && (mode == MODE_SHIFT) && !m0_rx_ff;
    end
  end

  // ********************************
  // asynchronous receive engine
  // ********************************
  logic rx_busy_ff;
  logic [3:0] rx_samp_ff, rx_idx_ff;
  logic [8:0] rx_sh_ff;
  logic rx_mid, rx_stop_now, rx_end, mp_on, ninth_in, addr_ok, accept;
  logic [7:0] rx_data;

  assign rx_mid = rx_busy_ff && rx_samp && rx_samp_ff == SAMPLE_MID;
  assign rx_stop_now = rx_mid && rx_idx_ff == (nine ? 4'hA : 4'h9);
  // mode 1 finishes at stop so the stop bit can be kept as ninth bit
  assign rx_end = (nine && !fe_access) ? (rx_mid && rx_idx_ff == 4'h9) : rx_stop_now;
  assign mp_on = sc_ff.multiproc_enable && (mode != MODE_SHIFT);
  assign ninth_in = nine ? (rx_idx_ff == 4'h9 ? rx_s2_ff : rx_sh_ff[8]) : rx_s2_ff;
  assign rx_data = nine ? (rx_idx_ff == 4'h9 ? rx_sh_ff[8:1] : rx_sh_ff[7:0]) : rx_sh_ff[8:1];
  assign addr_ok = ((rx_data ^ slave_address_ff) & smask_ff) == 8'h00;
  assign accept = !mp_on || (ninth_in && addr_ok);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_busy_ff <= 1'b0;
      rx_samp_ff <= 4'h0;
      rx_idx_ff <= 4'h0;
      rx_sh_ff <= 9'h000;
    end else if (!rx_busy_ff) begin
      rx_samp_ff <= 4'h0;
      rx_idx_ff <= 4'h0;
      if (mode != MODE_SHIFT && sc_ff.rx_enable && rx_prev_ff && !rx_s2_ff)
        rx_busy_ff <= 1'b1;
    end else begin
      if (rx_samp) rx_samp_ff <= rx_samp_ff + 4'h1;
      if (rx_samp && rx_samp_ff == SAMPLE_LAST) rx_idx_ff <= rx_idx_ff + 4'h1;
      if (rx_mid) begin
        if (rx_idx_ff == 4'h0 && rx_s2_ff) rx_busy_ff <= 1'b0;
        if (rx_idx_ff != 4'h0) rx_sh_ff <= {rx_s2_ff, rx_sh_ff[8:1]};
        if (rx_end) rx_busy_ff <= 1'b0;
      end
    end
  end

  assign fe_set = rx_stop_now && fe_access && !rx_s2_ff;
  assign rx_load = (rx_end && accept) || (m0_done && m0_rx_ff);
  assign rx_load_data = m0_rx_ff ? {m0_bit_ff, tx_sh_ff[10:4]} : rx_data;
  assign rb8_val = m0_rx_ff ? sc_ff.rx_ninth_bit : ninth_in;
  assign ri_set = rx_load;
  assign ti_set = (tx_shift && !m0_rx_ff && mode != MODE_SHIFT && tx_left_ff == 4'h2)
    || (m0_done && !m0_rx_ff);

  // ********************************
  // outputs
  // ********************************
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign txd = txd_ff;
  assign rxd_out = rxd_out_ff;
  assign rxd_oe = rxd_oe_ff;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_fe_sticky_hold: assert property (fe_ff && !wr_sc |=> fe_ff)
    else $error("framing error flag dropped without a write");
  a_bit7_read_view: assert property (arvalid && arready_ff && araddr[9:2] == IDX_SERIAL_CONTROL
    |=> rdata_ff[7] == $past(fe_access ? fe_ff : sc_ff.mode_select_bit0))
    else $error("control bit 7 shows the wrong field");
  a_mode0_half_period: assert property (mode == MODE_SHIFT && !bc_ff.shift_mode_clock_select
    && m0_tick |=> !m0_tick ##1 !m0_tick ##1 m0_tick)
    else $error("mode 0 half period is not three clocks");
  a_rx_enable_gate: assert property (!sc_ff.rx_enable && !rx_busy_ff |=> !rx_busy_ff)
    else $error("receiver started while disabled");
  a_ninth_bit_load: assert property (tx_load && mode == MODE_UART9_VAR
    |=> tx_sh_ff[9] == $past(sc_ff.tx_ninth_bit))
    else $error("ninth bit not taken from the control bit");
  a_brg_stopped: assert property (!bc_ff.generator_run |=> $stable(brg_cnt_ff) && !brg_tick_ff)
    else $error("baud generator moved while stopped");
  a_brg_reload_val: assert property (brg_tick_ff |-> brg_cnt_ff == $past(reload_ff))
    else $error("generator did not reload");
  a_ti_at_stop: assert property (ti_set && mode != MODE_SHIFT |=> tx_sh_ff[0] ##1 txd_ff)
    else $error("transmit done not at stop bit");
  a_mp_filter_ok: assert property (rx_end && mp_on && rx_load |-> ninth_in && addr_ok)
    else $error("multiprocessor frame accepted wrongly");
  a_mode2_rate: assert property (mode == MODE_UART9_FIXED && rate_doubler |-> tx_samp && rx_samp)
    else $error("mode 2 fast sample rate lost");

endmodule

/* File: tb/uart_remote_model.sv */
// remote asynchronous serial device facing the port's pins
`timescale 1ns/1ps
module uart_remote_model (
  // clock and pins
  input wire logic clk,
  input wire logic txd,
  output logic line
);
  int bit_clks = 16;
  int nbits = 10;
  int frames = 0;
  logic [9:0] got = 10'h000;
  // idle line sits high, as with a pull-up
  initial line = 1'h1;
  // ******
  // sender, lsb first
  // ******
  task automatic send(input logic [8:0] v, input int n, input logic stp);
    line <= 1'h0;
    repeat (bit_clks) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      line <= v[i];
      repeat (bit_clks) @(posedge clk);
    end
    line <= stp;
    repeat (bit_clks) @(posedge clk);
    line <= 1'h1;
    repeat (2 * bit_clks) @(posedge clk);
  endtask
  // ******
  // catcher, samples mid bit
  // ******
  initial forever begin
    @(negedge txd);
    got = 10'h000;
    repeat (bit_clks / 2) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_clks) @(posedge clk);
      got[i] = txd;
    end
    frames++;
  end
endmodule

/* File: tb/uart_serial_port_control_tb.sv */
// self-checking bench for the serial port control block
`timescale 1ns/1ps
module uart_serial_port_control_tb import uart_pkg::*;;
  localparam logic [9:0] SC = {IDX_SERIAL_CONTROL, 2'h0};
  localparam logic [9:0] BUF = {IDX_DATA_BUFFER, 2'h0};
  localparam logic [9:0] BAUD_RELOAD_VALUE = {IDX_BAUD_RELOAD, 2'h0};
  localparam logic [9:0] BC = {IDX_BAUD_CONTROL, 2'h0};
  localparam logic [9:0] SA = {IDX_SLAVE_ADDRESS, 2'h0};
  localparam logic [9:0] SM = {IDX_SLAVE_MASK, 2'h0};
  localparam logic [9:0] PC = {IDX_POWER_CONTROL, 2'h0};
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [9:0] awaddr = 10'h000, araddr = 10'h000;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic timer1_tick = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] tcnt = 2'h0;
  logic awready, wready, bvalid, arready, rvalid, rxd_out, rxd_oe, txd, rx_line;
  logic [1:0] bresp, rresp, rr, br;
  logic [7:0] m0_got = 8'h00;
  logic [31:0] rdata, d;
  int miscompares = 0, n_tests = 0, cyc = 0;
  wire logic rxd_pin = rxd_oe ? rxd_out : rx_line;
  uart_serial_port uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .timer1_tick(timer1_tick), .rxd_pin(rxd_pin), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .txd(txd));
  uart_remote_model rm (.clk(aclk), .txd(txd), .line(rx_line));
  // mode 0: data stands on the data line while the shift clock rises
  always @(posedge txd) if (rxd_oe === 1'h1) m0_got <= {rxd_out, m0_got[7:1]};
  always #5 aclk = ~aclk;
  // ******
  // timer 1 pulse every 4 clocks, hang guard
  // ******
  always @(posedge aclk) begin
    tcnt <= tcnt + 2'h1;
    timer1_tick <= (tcnt == 2'h3);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  // ******
  // bus tasks
  // ******
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    logic aw_p, w_p;
    aw_p = 1'h1;
    w_p = 1'h1;
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && awready === 1'h1) begin
        awvalid <= 1'h0;
        aw_p = 1'h0;
      end
      if (w_p && wready === 1'h1) begin
        wvalid <= 1'h0;
        w_p = 1'h0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'h1);
    br = bresp;
    bready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [9:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    d = rdata;
    rr = rresp;
    rready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic rc(input logic [9:0] a, input logic [7:0] e);
    rd(a);
    chk(d, {24'h0, e});
  endtask
  // waits past the stop bit so the next write finds the transmitter idle
  task automatic txf(input logic [7:0] v, input logic [9:0] e);
    int f;
    f = rm.frames;
    wr(BUF, v);
    while (rm.frames == f) @(posedge aclk);
    repeat (rm.bit_clks) @(posedge aclk);
    chk({22'h0, rm.got}, {22'h0, e});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ******
  // tests
  // ******
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rc(SC, 8'h00);
    rc(BAUD_RELOAD_VALUE, 8'h00);
    rc(BC, 8'h00);
    rc(SA, 8'h00);
    rc(SM, 8'h00);
    rd(10'h000);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    wr(10'h000, 8'h00);
    chk({30'h0, br}, {30'h0, RESP_SLVERR});
    wr(SA, 8'h5A);
    wr(SM, 8'hF0);
    wr(BAUD_RELOAD_VALUE, 8'hFE);
    wr(BC, 8'h1A);
    rc(SA, 8'h5A);
    rc(SM, 8'hF0);
    rc(BAUD_RELOAD_VALUE, 8'hFE);
    rc(BC, 8'h1A);
    $display("registers done");
    wr(PC, 8'h80);
    wr(SC, 8'h88);
    txf(8'hA5, 10'h3A5);
    rc(SC, 8'h8A);
    wr(SC, 8'h90);
    rm.send(9'h13C, 9, 1'h1);
    rc(SC, 8'h95);
    rc(BUF, 8'h3C);
    wr(SC, 8'h80);
    rm.send(9'h0C3, 9, 1'h1);
    rc(SC, 8'h80);
    $display("mode 2 done");
    wr(PC, 8'hC0);
    wr(SC, 8'h10);
    rc(SC, 8'h10);
    rm.send(9'h055, 9, 1'h0);
    rc(SC, 8'h91);
    wr(PC, 8'h80);
    wr(SC, 8'h90);
    rm.send(9'h155, 9, 1'h1);
    wr(PC, 8'hC0);
    rc(SC, 8'h95);
    wr(SC, 8'h10);
    rc(SC, 8'h10);
    wr(PC, 8'h80);
    $display("framing done");
    wr(SC, 8'hB0);
    rm.send(9'h163, 9, 1'h1);
    rd(SC);
    chk(d & 32'h1, 32'h0);
    rm.send(9'h153, 9, 1'h1);
    rc(SC, 8'hB5);
    rc(BUF, 8'h53);
    $display("address filter done");
    wr(SC, 8'h40);
    rm.bit_clks = 32;
    rm.nbits = 9;
    txf(8'h5C, 10'h15C);
    rc(SC, 8'h42);
    wr(BC, 8'h12);
    rm.bit_clks = 64;
    txf(8'hA3, 10'h1A3);
    wr(SC, 8'hC8);
    rm.nbits = 10;
    txf(8'h3C, 10'h33C);
    rc(SC, 8'hCA);
    $display("mode 3 done");
    wr(SC, 8'h00);
    wr(BUF, 8'h96);
    repeat (80) @(posedge aclk);
    chk({24'h0, m0_got}, 32'h96);
    rc(SC, 8'h02);
    $display("mode 0 done");
    wr(SC, 8'h40);
    wr(BC, 8'h0A);
    wr(BUF, 8'h77);
    repeat (1500) @(posedge aclk);
    rc(SC, 8'h40);
    $display("mode 1 done");
    test_done();
  end
endmodule
